/* inc/psr_pkg.sv */
package psr_pkg;

   // register map, byte offsets within the system-control block
   localparam logic [31:0] PSR_SYSCTL_BASE    = 32'h400FE000;
   localparam logic [11:0] PSR_SERIAL_OFS     = 12'h044;
   localparam logic [11:0] PSR_GPIO_OFS       = 12'h048;
   localparam logic [11:0] PSR_CAP_TWO_OFS    = 12'h014;
   localparam logic [11:0] PSR_CAP_FOUR_OFS   = 12'h01C;
   localparam int          PSR_ADDR_W         = 12;

   // reset values
   localparam logic [31:0] PSR_SERIAL_RST     = 32'h00000000;
   localparam logic [31:0] PSR_GPIO_RST       = 32'h00000000;

   // writable positions of each register; reserved bits stay zero
   localparam logic [31:0] PSR_SERIAL_WMASK   = 32'h070F5337;
   localparam logic [31:0] PSR_GPIO_WMASK     = 32'h000000FF;

   // field positions in the serial-unit register and the port register
   localparam int PSR_ASYNC0_BIT   = 0;
   localparam int PSR_ASYNC1_BIT   = 1;
   localparam int PSR_ASYNC2_BIT   = 2;
   localparam int PSR_SYNC0_BIT    = 4;
   localparam int PSR_SYNC1_BIT    = 5;
   localparam int PSR_ENC0_BIT     = 8;
   localparam int PSR_ENC1_BIT     = 9;
   localparam int PSR_TWOWIRE0_BIT = 12;
   localparam int PSR_TWOWIRE1_BIT = 14;
   localparam int PSR_TIMER_LSB    = 16;
   localparam int PSR_COMP_LSB     = 24;
   localparam int PSR_PORT_LSB     = 0;

   // reset lines toward the units of the serial register
   typedef struct packed {
      logic [2:0] comparator_rst;
      logic [3:0] timer_rst;
      logic       twowire_unit_one_rst;
      logic       twowire_unit_zero_rst;
      logic       encoder_unit_one_rst;
      logic       encoder_unit_zero_rst;
      logic       sync_serial_one_rst;
      logic       sync_serial_zero_rst;
      logic       async_serial_two_rst;
      logic       async_serial_one_rst;
      logic       async_serial_zero_rst;
   } psr_unit_rst_s;

   // register bus request
   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [PSR_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
   } psr_bus_req_s;

endpackage : psr_pkg

/* core/psr_mask_reg.sv */
`timescale 1ns/1ps
// one masked control register: only present, writable bits change
module psr_mask_reg #(
   parameter logic [31:0] WMASK = 32'h00000000,
   parameter logic [31:0] RSTV  = 32'h00000000
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // write side
   input  wire logic        we_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [31:0] cap_i,
   // stored value
   output logic      [31:0] q_o
);

   // bits outside the mask keep their value, reserved ones stay zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_o <= RSTV;
      end else if (we_i) begin
         q_o <= (q_o & ~(WMASK & cap_i)) | (wdata_i & WMASK & cap_i);
      end
   end

endmodule : psr_mask_reg

/* core/psr_soft_reset.sv */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - port register at 0x048, resets to zero
// - port register writes masked by capability four
// - bits 7..0 reset ports A..H
// - reserved bits read zero, ignore writes
// - bit 12 resets two-wire unit zero
// - bits 9,8 reset encoder units one, zero
// - bits 5,4 reset sync serial one, zero
// - bits 2..0 reset async serial two..zero
// - serial register at 0x044, capability two masked
// - bits 19..16 timers, 26..24 comparators
module psr_soft_reset (
   // clock and reset
   input  wire logic                           clk_i,
   input  wire logic                           rst_i,
   // register port
   input  wire logic [psr_pkg::PSR_ADDR_W-1:0] addr_i,
   input  wire logic [31:0]                    wdata_i,
   input  wire logic                           wr_i,
   input  wire logic                           rd_i,
   output logic      [31:0]                    rdata_o,
   // capability inputs, fixed by the chip build
   input  wire logic [31:0]                    capability_mask_two_i,
   input  wire logic [31:0]                    capability_mask_four_i,
   // unit reset lines, high holds the unit in reset
   output psr_pkg::psr_unit_rst_s              unit_rst_o,
   output logic      [7:0]                     port_rst_o
);
   import psr_pkg::*;

   psr_bus_req_s req;
   logic [31:0]  serial_unit_reset_ctrl;
   logic [31:0]  gpio_port_reset_ctrl;
   logic         hit_serial;
   logic         hit_gpio;
   logic [31:0]  serial_live;
   logic [31:0]  gpio_live;

   // gather the bus into one carrier
   assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

   function automatic logic addr_is(input logic [PSR_ADDR_W-1:0] a,
                                    input logic [PSR_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction : addr_is

   assign hit_serial = addr_is(req.addr, PSR_SERIAL_OFS);
   assign hit_gpio   = addr_is(req.addr, PSR_GPIO_OFS);

   // bits that a write may change: writable and present in this build;
   // only the checks below read these, the registers apply the masks themselves
   assign serial_live = PSR_SERIAL_WMASK & capability_mask_two_i;
   assign gpio_live   = PSR_GPIO_WMASK & capability_mask_four_i;

   // serial, timer and comparator register
   psr_mask_reg #(
      .WMASK (PSR_SERIAL_WMASK),
      .RSTV  (PSR_SERIAL_RST)
   ) u_serial (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (req.wr && hit_serial),
      .wdata_i (req.wdata),
      .cap_i   (capability_mask_two_i),
      .q_o     (serial_unit_reset_ctrl)
   );

   // gpio port register
   psr_mask_reg #(
      .WMASK (PSR_GPIO_WMASK),
      .RSTV  (PSR_GPIO_RST)
   ) u_gpio (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (req.wr && hit_gpio),
      .wdata_i (req.wdata),
      .cap_i   (capability_mask_four_i),
      .q_o     (gpio_port_reset_ctrl)
   );

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h00000000;
      end else if (req.rd && hit_serial) begin
         rdata_o <= serial_unit_reset_ctrl & PSR_SERIAL_WMASK;
      end else if (req.rd && hit_gpio) begin
         rdata_o <= gpio_port_reset_ctrl & PSR_GPIO_WMASK;
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

   // registered reset lines; one cycle later than the register, glitch free
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         unit_rst_o <= '0;
      end else begin
         unit_rst_o.async_serial_zero_rst <= serial_unit_reset_ctrl[PSR_ASYNC0_BIT];
         unit_rst_o.async_serial_one_rst  <= serial_unit_reset_ctrl[PSR_ASYNC1_BIT];
         unit_rst_o.async_serial_two_rst  <= serial_unit_reset_ctrl[PSR_ASYNC2_BIT];
         unit_rst_o.sync_serial_zero_rst  <= serial_unit_reset_ctrl[PSR_SYNC0_BIT];
         unit_rst_o.sync_serial_one_rst   <= serial_unit_reset_ctrl[PSR_SYNC1_BIT];
         unit_rst_o.encoder_unit_zero_rst <= serial_unit_reset_ctrl[PSR_ENC0_BIT];
         unit_rst_o.encoder_unit_one_rst  <= serial_unit_reset_ctrl[PSR_ENC1_BIT];
         unit_rst_o.twowire_unit_zero_rst <= serial_unit_reset_ctrl[PSR_TWOWIRE0_BIT];
         unit_rst_o.twowire_unit_one_rst  <= serial_unit_reset_ctrl[PSR_TWOWIRE1_BIT];
         unit_rst_o.timer_rst      <= serial_unit_reset_ctrl[PSR_TIMER_LSB +: 4];
         unit_rst_o.comparator_rst <= serial_unit_reset_ctrl[PSR_COMP_LSB +: 3];
      end
   end

   // port resets, bit 0 is port A
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_rst_o <= 8'h00;
      end else begin
         port_rst_o <= gpio_port_reset_ctrl[PSR_PORT_LSB +: 8];
      end
   end

   // write path: a write changes only writable bits of units that are present,
   // so software on a smaller build cannot hold a missing unit in reset
   serial_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req.wr && hit_serial) |=>
         serial_unit_reset_ctrl == (($past(serial_unit_reset_ctrl) & ~$past(serial_live))
                                   | ($past(req.wdata) & $past(serial_live)))
   ) else $error("serial register write not masked as expected");

   gpio_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req.wr && hit_gpio) |=>
         gpio_port_reset_ctrl == (($past(gpio_port_reset_ctrl) & ~$past(gpio_live))
                                 | ($past(req.wdata) & $past(gpio_live)))
   ) else $error("port register write not masked as expected");

   // without a write to its offset a register keeps its value; a stray address
   // must reach neither of them
   serial_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(req.wr && hit_serial) |=> $stable(serial_unit_reset_ctrl)
   ) else $error("serial register changed without a write");

   gpio_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(req.wr && hit_gpio) |=> $stable(gpio_port_reset_ctrl)
   ) else $error("port register changed without a write");

   // reserved positions never hold a one, whatever software writes
   reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ((serial_unit_reset_ctrl & ~PSR_SERIAL_WMASK) == 32'h00000000)
      && ((gpio_port_reset_ctrl & ~PSR_GPIO_WMASK) == 32'h00000000)
   ) else $error("reserved control bit set");

   // read path: data stand in the cycle after the strobe, reserved bits as zero
   serial_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req.rd && hit_serial) |=>
         rdata_o == ($past(serial_unit_reset_ctrl) & PSR_SERIAL_WMASK)
   ) else $error("serial register read data wrong");

   gpio_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req.rd && hit_gpio) |=>
         rdata_o == ($past(gpio_port_reset_ctrl) & PSR_GPIO_WMASK)
   ) else $error("port register read data wrong");

   // no read, or an unmapped offset, leaves the read port at zero
   idle_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(req.rd && (hit_serial || hit_gpio)) |=> rdata_o == 32'h00000000
   ) else $error("read data present without a mapped read");

   // chip reset clears both registers and every line toward the units;
   // checked one edge on, since the first edge may be what applies the reset
   reset_clear_a: assert property (@(posedge clk_i)
      rst_i |=> (gpio_port_reset_ctrl == PSR_GPIO_RST)
                && (serial_unit_reset_ctrl == PSR_SERIAL_RST)
                && (unit_rst_o == '0) && (port_rst_o == 8'h00) && (rdata_o == 32'h00000000)
   ) else $error("reset left a control bit set");

   // port lines follow the register one edge later, one bit to one port
   port_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      port_rst_o == $past(gpio_port_reset_ctrl[PSR_PORT_LSB +: 8])
   ) else $error("port reset lines do not follow the register");

   // a port is put into reset only by a port-register write two edges before
   port_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(port_rst_o & ~$past(port_rst_o))) |-> $past(req.wr && hit_gpio, 2)
   ) else $error("port reset line rose without a write");

   // the same for the serial, timer and comparator units
   unit_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(unit_rst_o & ~$past(unit_rst_o))) |-> $past(req.wr && hit_serial, 2)
   ) else $error("unit reset line rose without a write");

   // three asynchronous serial units sit at the bottom of the register
   async_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      {unit_rst_o.async_serial_two_rst, unit_rst_o.async_serial_one_rst,
       unit_rst_o.async_serial_zero_rst} == $past(serial_unit_reset_ctrl[PSR_ASYNC0_BIT +: 3])
   ) else $error("async serial reset lines do not follow the register");

   // two synchronous serial units, unit one above unit zero
   sync_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      {unit_rst_o.sync_serial_one_rst, unit_rst_o.sync_serial_zero_rst}
         == $past(serial_unit_reset_ctrl[PSR_SYNC0_BIT +: 2])
   ) else $error("sync serial reset lines do not follow the register");

   // two encoder units, unit one above unit zero
   encoder_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      {unit_rst_o.encoder_unit_one_rst, unit_rst_o.encoder_unit_zero_rst}
         == $past(serial_unit_reset_ctrl[PSR_ENC0_BIT +: 2])
   ) else $error("encoder reset lines do not follow the register");

   // first two-wire unit, next to the reserved bit above it
   twowire_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
      unit_rst_o.twowire_unit_zero_rst == $past(serial_unit_reset_ctrl[PSR_TWOWIRE0_BIT])
   ) else $error("two-wire reset line does not follow the register");

   // second two-wire unit sits two bits higher
   twowire_one_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
      unit_rst_o.twowire_unit_one_rst == $past(serial_unit_reset_ctrl[PSR_TWOWIRE1_BIT])
   ) else $error("second two-wire reset line does not follow the register");

   // four timers in the third byte
   timer_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      unit_rst_o.timer_rst == $past(serial_unit_reset_ctrl[PSR_TIMER_LSB +: 4])
   ) else $error("timer reset lines do not follow the register");

   // three comparators in the top byte
   comp_lines_a: assert property (@(posedge clk_i) disable iff (rst_i)
      unit_rst_o.comparator_rst == $past(serial_unit_reset_ctrl[PSR_COMP_LSB +: 3])
   ) else $error("comparator reset lines do not follow the register");

endmodule : psr_soft_reset

/* tb/psr_soft_reset_bench.sv */
`timescale 1ns/1ps
module psr_soft_reset_bench;
   import psr_pkg::*;
   logic                  clk_i   = 1'b0;
   logic                  rst_i   = 1'b1;
   logic                  wr_i    = 1'b0;
   logic                  rd_i    = 1'b0;
   logic [PSR_ADDR_W-1:0] addr_i  = '0;
   logic [31:0]           wdata_i = '0;
   logic [31:0]           cap2    = 32'hFFFFFFFF;
   logic [31:0]           cap4    = 32'hFFFFFFFF;
   logic [31:0]           rdata_o;
   psr_unit_rst_s         unit_rst_o;
   logic [7:0]            port_rst_o;
   int                    error_cnt = 0;
   int                    n_tests   = 0;

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   psr_soft_reset dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .capability_mask_two_i(cap2),
      .capability_mask_four_i(cap4), .unit_rst_o(unit_rst_o), .port_rst_o(port_rst_o));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // expected unit lines, in the struct's packing order
   function automatic logic [15:0] units(input logic [31:0] r);
      return {r[26:24], r[19:16], r[14], r[12], r[9:8], r[5:4], r[2:0]};
   endfunction : units

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
   endtask : rd

   task automatic both(input logic [31:0] es, input logic [31:0] eg);
      logic [31:0] d;
      rd(PSR_SERIAL_OFS, d);
      chk("serial reg", d, es);
      rd(PSR_GPIO_OFS, d);
      chk("port reg", d, eg);
      chk("unit lines", {16'h0, unit_rst_o}, {16'h0, units(es)});
      chk("port lines", {24'h0, port_rst_o}, eg);
   endtask : both

   // one bit at a time, so swapped or reserved lines show up
   task automatic t_walk();
      for (int i = 0; i < 32; i++) begin
         wr(PSR_SERIAL_OFS, 32'h1 << i);
         wr(PSR_GPIO_OFS, 32'h1 << i);
         both((32'h1 << i) & 32'h070F5337, (32'h1 << i) & 32'hFF);
      end
      $display("test walk done");
   endtask : t_walk

   // absent units keep their old bit whichever way software writes
   task automatic t_mask();
      wr(PSR_SERIAL_OFS, 32'hFFFFFFFF);
      wr(PSR_GPIO_OFS, 32'hFFFFFFFF);
      cap2 <= 32'h01051011;
      cap4 <= 32'h0000000F;
      wr(PSR_SERIAL_OFS, 32'h0);
      wr(PSR_GPIO_OFS, 32'h0);
      both(32'h060A4326, 32'hF0);
      cap2 <= 32'h0;
      cap4 <= 32'h0;
      wr(PSR_SERIAL_OFS, 32'hFFFFFFFF);
      wr(PSR_GPIO_OFS, 32'h0);
      both(32'h060A4326, 32'hF0);
      cap2 <= 32'hFFFFFFFF;
      cap4 <= 32'hFFFFFFFF;
      wr(PSR_SERIAL_OFS, 32'h0);
      wr(PSR_GPIO_OFS, 32'h0);
      both(32'h0, 32'h0);
      $display("test mask done");
   endtask : t_mask

   // stray address, then a reset in mid-run
   task automatic t_stray_reset();
      wr(12'h04C, 32'hFFFFFFFF);
      both(32'h0, 32'h0);
      wr(PSR_SERIAL_OFS, 32'hFFFFFFFF);
      wr(PSR_GPIO_OFS, 32'hFFFFFFFF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      both(32'h0, 32'h0);
      $display("test reset done");
   endtask : t_stray_reset

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      both(32'h0, 32'h0);
      t_walk();
      t_mask();
      t_stray_reset();
      summarize();
   end

   // watchdog, well past the expected run
   initial begin
      #20000;
      error_cnt++;
      summarize();
   end
endmodule : psr_soft_reset_bench
